// >>> fsw_pkg.sv
// shared types and constants for the flash status and write-enable block
package fsw_pkg;

   // address map of the array
   localparam int unsigned ADDR_W          = 24;
   localparam int unsigned SECTOR_LSB      = 12;           // 4 Kbyte sectors
   localparam int unsigned BLK32_LSB       = 15;           // eight sectors per 32 Kbyte block
   localparam int unsigned BLK64_LSB       = 16;           // sixteen sectors per 64 Kbyte block
   localparam logic [23:0] TOP_SECTOR_BASE = 24'hFF_F000;  // last sector start
   localparam logic [8:0]  BLOCK_SPAN      = 9'h100;       // 64 Kbyte blocks in the array
   localparam logic [3:0]  BP_ALL_LEVEL    = 4'h9;         // level that covers every block

   // status register value after reset
   localparam logic [7:0]  SR_RESET        = 8'h00;

   // default length of an internal register write cycle, in sys_clk cycles
   localparam int unsigned NV_WRITE_CYCLES_DEF = 16;
   localparam int unsigned TIMER_W             = 16;

   // stages of every clock-crossing synchroniser
   localparam int unsigned SYNC_STAGES = 3;

   // decoded instructions presented by the serial front end
   typedef enum logic [3:0] {
      OP_NONE, OP_WRITE_ENABLE_CMD, OP_WRITE_DISABLE_CMD, OP_STATUS_READ_CMD, OP_STATUS_WRITE_CMD, OP_PROGRAM, OP_SECT_ERASE,
      OP_BLK32_ERASE, OP_BLK64_ERASE, OP_FULL_ERASE, OP_NV_REG_WRITE,
      OP_VOL_REG_WRITE, OP_DYN_PROT_WRITE, OP_RD_OTHER, OP_SUSPEND, OP_SW_RESET
   } fsw_op_t;

   // one instruction with its address and data byte
   typedef struct packed {
      fsw_op_t     op;
      logic [23:0] addr;
      logic [7:0]  data;
   } fsw_cmd_t;

   // status register, bit 7 down to bit 0
   typedef struct packed {
      logic       status_lock_bit;
      logic       quad_enable_bit;
      logic [3:0] protect_level;
      logic       write_enable_latch;
      logic       busy_flag;
   } fsw_status_t;

   // request to the array engine
   typedef struct packed {
      logic        valid;
      fsw_op_t     op;
      logic [23:0] addr;
      logic [11:0] sector;
      logic [8:0]  blk32;
      logic [7:0]  blk64;
   } fsw_arr_req_t;

   // busy sources
   typedef enum logic [1:0] {ST_IDLE, ST_ARRAY, ST_NVREG} fsw_state_t;

endpackage

// >>> fsw_flash_status.sv
// status register, write enable latch and busy control of a serial flash
// Contract
// - 24-bit space in 4 KB sectors, 32 KB and 64 KB blocks; top sector FFF000h.
// - status byte: lock, quad enable, four protect level bits, latch, busy; reset zero.
// - busy reads 1 during a write cycle, 0 when ready; writes ignore it.
// - busy set for program, erase and nonvolatile register writes.
// - while busy only reads, resets and suspend are honoured.
// - busy clears on completion, pass or fail; new instructions then accepted.
// - latch clear inhibits write-class operations; latch set permits them.
// - write-enable instruction sets latch, write-disable instruction clears it.
// - latch clears automatically when any write-class operation completes.
// - volatile register and dynamic protect writes need no latch.
// - status write instruction never alters the latch itself.
// - lock, quad and protect bits change only by status write.
// - status read returns the whole status byte.
// - quad enable bit turns the quad output function on or off.
// - nonzero protect level write-protects its top blocks.
// - lock bit with write-protect pin low blocks status writes.
// - full erase ignored unless all protect level bits are zero.
`timescale 1ns/1ps
module fsw_flash_status #(
   parameter int unsigned NV_WRITE_CYCLES = fsw_pkg::NV_WRITE_CYCLES_DEF
) (
   // system clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 rst_n,
   // instruction link on its own clock
   input  wire logic                 lnk_clk,
   input  wire logic                 lnk_cmd_valid,
   input  wire fsw_pkg::fsw_cmd_t    lnk_cmd,
   output logic                      lnk_pend,
   output logic                      lnk_done,
   output logic [7:0]                lnk_status,
   // write-protect pin
   input  wire logic                 wp_n,
   // array engine
   output fsw_pkg::fsw_arr_req_t     arr_req,
   output logic                      arr_suspend,
   output logic                      arr_abort,
   input  wire logic                 arr_done,
   // status bits for the rest of the device
   output logic                      quad_en,
   output logic [3:0]                protect_level
);

   // system-domain state
   typedef struct packed {
      fsw_pkg::fsw_state_t             state;
      fsw_pkg::fsw_status_t            sr;
      logic [5:0]                      nv_pend;
      logic                            nv_sr;
      logic [fsw_pkg::TIMER_W-1:0]     timer;
      logic [fsw_pkg::SYNC_STAGES-1:0] wp_sync;
      logic                            wp_lvl;
      logic [fsw_pkg::SYNC_STAGES-1:0] req_sync;
      logic                            req_seen;
      logic                            ack_tog;
      logic [7:0]                      snap;
      fsw_pkg::fsw_arr_req_t           arr_req;
      logic                            arr_susp;
      logic                            arr_abort;
   } fsw_sys_t;

   // link-domain state
   typedef struct packed {
      logic                            req_tog;
      fsw_pkg::fsw_cmd_t               cmd;
      logic [fsw_pkg::SYNC_STAGES-1:0] ack_sync;
      logic                            ack_seen;
      logic                            pend;
      logic [7:0]                      status;
      logic                            done;
   } fsw_lnk_t;

   fsw_sys_t          sys_ff;
   fsw_sys_t          nxt_sys;
   fsw_lnk_t          lnk_ff;
   fsw_lnk_t          nxt_lnk;
   logic              new_req;
   fsw_pkg::fsw_op_t  cur_op;
   logic              sr_locked;

   // protected-area test for a 64 KB block against the protect level
   function automatic logic prot_hit(input logic [7:0] blk, input logic [3:0] lvl);
      logic [8:0] lim;
      lim = fsw_pkg::BLOCK_SPAN - (9'h001 << (lvl - 4'h1));
      if (lvl == 4'h0) begin
         return 1'b0;
      end else if (lvl >= fsw_pkg::BP_ALL_LEVEL) begin
         return 1'b1;
      end
      return {1'b0, blk} >= lim;
   endfunction

   // request detection once the second and third synchroniser stages agree
   assign new_req   = (sys_ff.req_sync[1] == sys_ff.req_sync[2]) &&
                      (sys_ff.req_sync[2] != sys_ff.req_seen);
   assign cur_op    = lnk_ff.cmd.op;
   assign sr_locked = sys_ff.sr.status_lock_bit && !sys_ff.wp_lvl;

   // system-domain next state
   always_comb begin
      nxt_sys                 = sys_ff;
      nxt_sys.wp_sync         = {sys_ff.wp_sync[1:0], wp_n};
      nxt_sys.req_sync        = {sys_ff.req_sync[1:0], lnk_ff.req_tog};
      nxt_sys.arr_req.valid   = 1'b0;
      nxt_sys.arr_susp        = 1'b0;
      nxt_sys.arr_abort       = 1'b0;
      if (sys_ff.wp_sync[1] == sys_ff.wp_sync[2]) begin
         nxt_sys.wp_lvl = sys_ff.wp_sync[2];
      end
      // completion of a running write cycle, successful or not
      unique case (sys_ff.state)
         fsw_pkg::ST_IDLE: begin
         end
         fsw_pkg::ST_ARRAY: begin
            if (arr_done) begin
               nxt_sys.state                 = fsw_pkg::ST_IDLE;
               nxt_sys.sr.busy_flag          = 1'b0;
               nxt_sys.sr.write_enable_latch = 1'b0;
            end
         end
         fsw_pkg::ST_NVREG: begin
            if (sys_ff.timer == '0) begin
               nxt_sys.state                 = fsw_pkg::ST_IDLE;
               nxt_sys.sr.busy_flag          = 1'b0;
               nxt_sys.sr.write_enable_latch = 1'b0;
               if (sys_ff.nv_sr) begin
                  {nxt_sys.sr.status_lock_bit, nxt_sys.sr.quad_enable_bit,
                   nxt_sys.sr.protect_level} = sys_ff.nv_pend;
               end
            end else begin
               nxt_sys.timer = sys_ff.timer - 1'b1;
            end
         end
      endcase
      // instruction handling
      if (new_req) begin
         nxt_sys.req_seen = sys_ff.req_sync[2];
         nxt_sys.ack_tog  = ~sys_ff.ack_tog;
         if (nxt_sys.sr.busy_flag) begin
            // only resets and suspend act while busy; reads just answer
            if (cur_op == fsw_pkg::OP_SW_RESET) begin
               nxt_sys.state                 = fsw_pkg::ST_IDLE;
               nxt_sys.sr.busy_flag          = 1'b0;
               nxt_sys.sr.write_enable_latch = 1'b0;
               nxt_sys.arr_abort             = (sys_ff.state == fsw_pkg::ST_ARRAY);
            end else if (cur_op == fsw_pkg::OP_SUSPEND) begin
               nxt_sys.arr_susp = (sys_ff.state == fsw_pkg::ST_ARRAY);
            end
         end else begin
            unique case (cur_op)
               fsw_pkg::OP_WRITE_ENABLE_CMD: nxt_sys.sr.write_enable_latch = 1'b1;
               fsw_pkg::OP_WRITE_DISABLE_CMD: nxt_sys.sr.write_enable_latch = 1'b0;
               fsw_pkg::OP_SW_RESET: nxt_sys.sr.write_enable_latch = 1'b0;
               fsw_pkg::OP_STATUS_WRITE_CMD: begin
                  // latch untouched here; dropped without latch or when locked
                  // gates use the post-completion view, so a finished cycle's latch is gone
                  if (nxt_sys.sr.write_enable_latch &&
                      !(nxt_sys.sr.status_lock_bit && !sys_ff.wp_lvl)) begin
                     nxt_sys.state        = fsw_pkg::ST_NVREG;
                     nxt_sys.sr.busy_flag = 1'b1;
                     nxt_sys.nv_sr        = 1'b1;
                     nxt_sys.nv_pend      = lnk_ff.cmd.data[7:2];
                     nxt_sys.timer        = fsw_pkg::TIMER_W'(NV_WRITE_CYCLES - 1);
                  end
               end
               fsw_pkg::OP_NV_REG_WRITE: begin
                  if (nxt_sys.sr.write_enable_latch) begin
                     nxt_sys.state        = fsw_pkg::ST_NVREG;
                     nxt_sys.sr.busy_flag = 1'b1;
                     nxt_sys.nv_sr        = 1'b0;
                     nxt_sys.timer        = fsw_pkg::TIMER_W'(NV_WRITE_CYCLES - 1);
                  end
               end
               fsw_pkg::OP_PROGRAM, fsw_pkg::OP_SECT_ERASE, fsw_pkg::OP_BLK32_ERASE,
               fsw_pkg::OP_BLK64_ERASE, fsw_pkg::OP_FULL_ERASE: begin
                  // latch, protection and full-erase
                  if (nxt_sys.sr.write_enable_latch &&
                      ((cur_op == fsw_pkg::OP_FULL_ERASE) ?
                       (nxt_sys.sr.protect_level == 4'h0) :
                       !prot_hit(lnk_ff.cmd.addr[23:fsw_pkg::BLK64_LSB],
                                 nxt_sys.sr.protect_level))) begin
                     nxt_sys.state          = fsw_pkg::ST_ARRAY;
                     nxt_sys.sr.busy_flag   = 1'b1;
                     nxt_sys.arr_req.valid  = 1'b1;
                     nxt_sys.arr_req.op     = cur_op;
                     nxt_sys.arr_req.addr   = lnk_ff.cmd.addr;
                     // array indices
                     nxt_sys.arr_req.sector = lnk_ff.cmd.addr[23:fsw_pkg::SECTOR_LSB];
                     nxt_sys.arr_req.blk32  = lnk_ff.cmd.addr[23:fsw_pkg::BLK32_LSB];
                     nxt_sys.arr_req.blk64  = lnk_ff.cmd.addr[23:fsw_pkg::BLK64_LSB];
                  end
               end
               // volatile writes are handled outside and need no latch
               fsw_pkg::OP_VOL_REG_WRITE, fsw_pkg::OP_DYN_PROT_WRITE: begin
               end
               fsw_pkg::OP_NONE, fsw_pkg::OP_STATUS_READ_CMD, fsw_pkg::OP_RD_OTHER,
               fsw_pkg::OP_SUSPEND: begin
               end
            endcase
         end
         nxt_sys.snap = nxt_sys.sr;  // full status byte answered
      end
   end

   // system-domain registers; busy has no write path
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sys_ff         <= '0;
         sys_ff.sr      <= fsw_pkg::SR_RESET;
         sys_ff.wp_sync <= '1;  // pin idles high: no false low level after reset
         sys_ff.wp_lvl  <= 1'b1;
      end else begin
         sys_ff <= nxt_sys;
      end
   end

   // link-domain next state
   always_comb begin
      nxt_lnk          = lnk_ff;
      nxt_lnk.ack_sync = {lnk_ff.ack_sync[1:0], sys_ff.ack_tog};
      nxt_lnk.done     = 1'b0;
      if ((lnk_ff.ack_sync[1] == lnk_ff.ack_sync[2]) &&
          (lnk_ff.ack_sync[2] != lnk_ff.ack_seen)) begin
         nxt_lnk.ack_seen = lnk_ff.ack_sync[2];
         nxt_lnk.pend     = 1'b0;
         nxt_lnk.status   = sys_ff.snap;  // stable since the acknowledge toggled
         nxt_lnk.done     = 1'b1;
      end
      if (lnk_cmd_valid && !lnk_ff.pend) begin
         nxt_lnk.cmd     = lnk_cmd;
         nxt_lnk.req_tog = ~lnk_ff.req_tog;
         nxt_lnk.pend    = 1'b1;
      end
   end

   // link-domain registers
   always_ff @(posedge lnk_clk or negedge rst_n) begin
      if (!rst_n) begin
         lnk_ff <= '0;
      end else begin
         lnk_ff <= nxt_lnk;
      end
   end

   // outputs straight from flip-flops; quad enable drives the pin mux
   assign lnk_pend      = lnk_ff.pend;
   assign lnk_done      = lnk_ff.done;
   assign lnk_status    = lnk_ff.status;
   assign arr_req       = sys_ff.arr_req;
   assign arr_suspend   = sys_ff.arr_susp;
   assign arr_abort     = sys_ff.arr_abort;
   assign quad_en       = sys_ff.sr.quad_enable_bit;
   assign protect_level = sys_ff.sr.protect_level;

   // accepted status write
   sequence status_write_cmd_go_s;
      new_req && cur_op == fsw_pkg::OP_STATUS_WRITE_CMD && !sys_ff.sr.busy_flag &&
      sys_ff.sr.write_enable_latch && !sr_locked;
   endsequence

   // array completion
   sequence arr_end_s;
      sys_ff.state == fsw_pkg::ST_ARRAY && arr_done && !new_req;
   endsequence

   busy_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      arr_end_s |=> !sys_ff.sr.busy_flag && sys_ff.state == fsw_pkg::ST_IDLE)
      else $error("busy not cleared after array completion");

   latch_autoclr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      arr_end_s |=> !sys_ff.sr.write_enable_latch)
      else $error("latch not cleared after write completion");

   latch_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      new_req && cur_op == fsw_pkg::OP_WRITE_ENABLE_CMD && !sys_ff.sr.busy_flag &&
      sys_ff.state == fsw_pkg::ST_IDLE |=> sys_ff.sr.write_enable_latch)
      else $error("write enable did not set latch");

   latch_clr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      new_req && cur_op == fsw_pkg::OP_WRITE_DISABLE_CMD && !sys_ff.sr.busy_flag &&
      sys_ff.state == fsw_pkg::ST_IDLE |=> !sys_ff.sr.write_enable_latch)
      else $error("write disable did not clear latch");

   latch_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      sys_ff.arr_req.valid |-> $past(sys_ff.sr.write_enable_latch) && sys_ff.sr.busy_flag)
      else $error("array request without latch");

   full_erase_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      sys_ff.arr_req.valid && sys_ff.arr_req.op == fsw_pkg::OP_FULL_ERASE
      |-> sys_ff.sr.protect_level == 4'h0)
      else $error("full erase with protection set");

   protect_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      sys_ff.arr_req.valid && sys_ff.arr_req.op != fsw_pkg::OP_FULL_ERASE
      |-> !prot_hit(sys_ff.arr_req.blk64, sys_ff.sr.protect_level))
      else $error("request to protected block");

   sr_locked_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      new_req && cur_op == fsw_pkg::OP_STATUS_WRITE_CMD && sr_locked &&
      sys_ff.state == fsw_pkg::ST_IDLE |=> sys_ff.state == fsw_pkg::ST_IDLE)
      else $error("locked status write accepted");

   status_write_cmd_busy_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      status_write_cmd_go_s |=> sys_ff.sr.busy_flag[*2] ##0
      sys_ff.sr.write_enable_latch)
      else $error("status write busy or latch wrong");

   busy_ignore_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      new_req && sys_ff.sr.busy_flag && !arr_done &&
      !(sys_ff.state == fsw_pkg::ST_NVREG && sys_ff.timer == '0)
      |=> !sys_ff.arr_req.valid && $stable(sys_ff.sr.protect_level))
      else $error("instruction acted on while busy");

   ack_return_a: assert property (@(posedge lnk_clk) disable iff (!rst_n)
      lnk_ff.done |-> !lnk_ff.pend)
      else $error("answer while request still outstanding");

endmodule // fsw_flash_status

// >>> fsw_host_model.sv
// host controller model that turns bench requests into link instructions
`timescale 1ns/1ps
module fsw_host_model (
   // link clock and reset
   input  wire logic              lnk_clk,
   input  wire logic              rst_n,
   // bench side
   input  wire logic              h_go,
   input  wire fsw_pkg::fsw_cmd_t h_cmd,
   output logic                   h_ack,
   output logic [7:0]             h_status,
   // link side
   output logic                   lnk_cmd_valid,
   output fsw_pkg::fsw_cmd_t      lnk_cmd,
   input  wire logic              lnk_pend,
   input  wire logic              lnk_done,
   input  wire logic [7:0]        lnk_status
);
   logic wait_ff;

   // one request at a time; a released command bus shows the inverse of its last value
   always_ff @(posedge lnk_clk or negedge rst_n) begin
      if (!rst_n) begin
         lnk_cmd_valid <= 1'b0;
         lnk_cmd       <= '0;
         wait_ff       <= 1'b0;
         h_ack         <= 1'b0;
         h_status      <= 8'h00;
      end else begin
         if (lnk_cmd_valid && !lnk_pend) begin
            lnk_cmd_valid <= 1'b0;
            lnk_cmd       <= fsw_pkg::fsw_cmd_t'(~lnk_cmd);
            wait_ff       <= 1'b1;
         end else if (!lnk_cmd_valid && !wait_ff && !h_ack && h_go) begin
            lnk_cmd_valid <= 1'b1;
            lnk_cmd       <= h_cmd;
         end
         if (wait_ff && lnk_done) begin
            wait_ff  <= 1'b0;
            h_ack    <= 1'b1;
            h_status <= lnk_status;
         end
         if (h_ack && !h_go) begin
            h_ack <= 1'b0;
         end
      end
   end
endmodule // fsw_host_model

// >>> test_flash_status_write_enable.sv
// self-checking bench for the status register and write-enable block
`timescale 1ns/1ps
module test_flash_status_write_enable;
   logic                  sys_clk, rst_n, lnk_clk, wp_n, arr_done, h_go, h_ack;
   logic                  lnk_cmd_valid, lnk_pend, lnk_done, arr_suspend, arr_abort;
   logic                  quad_en;
   logic [7:0]            lnk_status, h_status;
   logic [3:0]            protect_level;
   fsw_pkg::fsw_cmd_t     lnk_cmd, h_cmd;
   fsw_pkg::fsw_arr_req_t arr_req, last_req;
   int                    bad_count, n_checks, n_req, eng_cnt, eng_dly, n;
   int                    n_susp, n_abort;

   fsw_flash_status #(.NV_WRITE_CYCLES(2)) i_dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .lnk_clk(lnk_clk),
      .lnk_cmd_valid(lnk_cmd_valid), .lnk_cmd(lnk_cmd), .lnk_pend(lnk_pend),
      .lnk_done(lnk_done), .lnk_status(lnk_status), .wp_n(wp_n), .arr_req(arr_req),
      .arr_suspend(arr_suspend), .arr_abort(arr_abort), .arr_done(arr_done),
      .quad_en(quad_en), .protect_level(protect_level));

   fsw_host_model i_host (
      .lnk_clk(lnk_clk), .rst_n(rst_n), .h_go(h_go), .h_cmd(h_cmd), .h_ack(h_ack),
      .h_status(h_status), .lnk_cmd_valid(lnk_cmd_valid), .lnk_cmd(lnk_cmd),
      .lnk_pend(lnk_pend), .lnk_done(lnk_done), .lnk_status(lnk_status));

   // clocks: 40 ns system, 48 ns link with an unrelated phase
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   initial begin
      lnk_clk = 1'b0;
      #7;
      forever #24 lnk_clk = ~lnk_clk;
   end

   // array engine stand-in: counts down a set delay, then pulses done; abort stops it
   always @(negedge sys_clk) begin
      arr_done <= 1'b0;
      if (arr_suspend === 1'b1) n_susp <= n_susp + 1;
      if (arr_abort === 1'b1) n_abort <= n_abort + 1;
      if (arr_req.valid === 1'b1) begin
         n_req    <= n_req + 1;
         last_req <= arr_req;
         eng_cnt  <= eng_dly;
      end else if (arr_abort === 1'b1) begin
         eng_cnt  <= 0;
      end else if (eng_cnt > 0) begin
         eng_cnt  <= eng_cnt - 1;
         arr_done <= (eng_cnt == 1);
      end
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic timeout();
      bad_count++;
      $display("BAD t=%0t wait ran out", $time);
      end_of_test();
   endtask

   // one instruction through the host model, command held until answered
   task automatic send(input fsw_pkg::fsw_op_t op, input logic [23:0] a, input logic [7:0] d);
      int i;
      @(negedge sys_clk);
      h_cmd = '{op, a, d};
      h_go  = 1'b1;
      for (i = 0; i < 200 && h_ack !== 1'b1; i++) @(negedge sys_clk);
      if (h_ack !== 1'b1) timeout();
      h_go = 1'b0;
      for (i = 0; i < 200 && h_ack !== 1'b0; i++) @(negedge sys_clk);
      if (h_ack !== 1'b0) timeout();
   endtask

   task automatic rd(input logic [7:0] exp);
      send(fsw_pkg::OP_STATUS_READ_CMD, 24'h00_0000, 8'h00);
      chk(h_status, exp);
   endtask

   task automatic wait_ready();
      int i;
      send(fsw_pkg::OP_STATUS_READ_CMD, 24'h00_0000, 8'h00);
      for (i = 0; i < 30 && h_status[0] !== 1'b0; i++) send(fsw_pkg::OP_STATUS_READ_CMD, 24'h0, 8'h0);
      if (h_status[0] !== 1'b0) timeout();
   endtask

   task automatic t_reset();
      rd(8'h00);
      chk(quad_en, 1'b0);
      chk(protect_level, 4'h0);
      $display("reset test done");
   endtask

   task automatic t_latch();
      send(fsw_pkg::OP_WRITE_ENABLE_CMD, 24'h00_0000, 8'h00);
      chk(h_status, 8'h02);
      rd(8'h02);
      send(fsw_pkg::OP_WRITE_DISABLE_CMD, 24'h00_0000, 8'h00);
      rd(8'h00);
      $display("latch test done");
   endtask

   // write-class and volatile writes with the latch clear
   task automatic t_refuse();
      fsw_pkg::fsw_op_t ops[9];
      ops = '{fsw_pkg::OP_PROGRAM, fsw_pkg::OP_SECT_ERASE, fsw_pkg::OP_BLK32_ERASE,
              fsw_pkg::OP_BLK64_ERASE, fsw_pkg::OP_FULL_ERASE, fsw_pkg::OP_NV_REG_WRITE,
              fsw_pkg::OP_STATUS_WRITE_CMD, fsw_pkg::OP_VOL_REG_WRITE, fsw_pkg::OP_DYN_PROT_WRITE};
      foreach (ops[k]) begin
         n = n_req;
         send(ops[k], 24'h00_1000, 8'hFC);
         repeat (5) @(negedge sys_clk);
         rd(8'h00);
         chk(n_req, n);
      end
      $display("refuse test done");
   endtask

   task automatic t_program();
      eng_dly = 200;
      send(fsw_pkg::OP_WRITE_ENABLE_CMD, 24'h00_0000, 8'h00);
      n = n_req;
      send(fsw_pkg::OP_PROGRAM, 24'hFF_F123, 8'h00);
      rd(8'h03);
      chk(n_req, n + 1);
      chk(last_req.sector, 12'hFFF);
      chk(last_req.blk64, 8'hFF);
      chk(last_req.blk32, 9'h1FF);
      send(fsw_pkg::OP_WRITE_DISABLE_CMD, 24'h00_0000, 8'h00);
      send(fsw_pkg::OP_SECT_ERASE, 24'h00_0000, 8'h00);
      rd(8'h03);
      chk(n_req, n + 1);
      wait_ready();
      rd(8'h00);
      eng_dly = 1;
      send(fsw_pkg::OP_WRITE_ENABLE_CMD, 24'h00_0000, 8'h00);
      send(fsw_pkg::OP_BLK64_ERASE, 24'h12_3456, 8'h00);
      chk(last_req.sector, 12'h123);
      chk(last_req.blk32, 9'h024);
      chk(last_req.blk64, 8'h12);
      wait_ready();
      rd(8'h00);
      $display("program test done");
   endtask

   // suspend and software reset while an array operation runs
   task automatic t_abort();
      eng_dly = 400;
      send(fsw_pkg::OP_WRITE_ENABLE_CMD, 24'h00_0000, 8'h00);
      n = n_susp;
      send(fsw_pkg::OP_PROGRAM, 24'h00_2000, 8'h00);
      send(fsw_pkg::OP_SUSPEND, 24'h00_0000, 8'h00);
      chk(n_susp, n + 1);
      rd(8'h03);
      n = n_abort;
      send(fsw_pkg::OP_SW_RESET, 24'h00_0000, 8'h00);
      chk(n_abort, n + 1);
      rd(8'h00);
      eng_dly = 1;
      $display("abort test done");
   endtask

   task automatic t_status_write_cmd();
      send(fsw_pkg::OP_WRITE_ENABLE_CMD, 24'h00_0000, 8'h00);
      send(fsw_pkg::OP_STATUS_WRITE_CMD, 24'h00_0000, 8'h47);
      wait_ready();
      rd(8'h44);
      chk(quad_en, 1'b1);
      chk(protect_level, 4'h1);
      send(fsw_pkg::OP_WRITE_ENABLE_CMD, 24'h00_0000, 8'h00);
      n = n_req;
      send(fsw_pkg::OP_FULL_ERASE, 24'h00_0000, 8'h00);
      send(fsw_pkg::OP_PROGRAM, 24'hFF_0000, 8'h00);
      rd(8'h46);
      chk(n_req, n);
      send(fsw_pkg::OP_PROGRAM, 24'h00_0000, 8'h00);
      chk(n_req, n + 1);
      wait_ready();
      rd(8'h44);
      $display("status write test done");
   endtask

   task automatic t_lock();
      send(fsw_pkg::OP_WRITE_ENABLE_CMD, 24'h00_0000, 8'h00);
      send(fsw_pkg::OP_STATUS_WRITE_CMD, 24'h00_0000, 8'h80);
      wait_ready();
      wp_n = 1'b0;
      repeat (5) @(negedge sys_clk);
      send(fsw_pkg::OP_WRITE_ENABLE_CMD, 24'h00_0000, 8'h00);
      send(fsw_pkg::OP_STATUS_WRITE_CMD, 24'h00_0000, 8'h00);
      repeat (10) @(negedge sys_clk);
      rd(8'h82);
      wp_n = 1'b1;
      repeat (5) @(negedge sys_clk);
      send(fsw_pkg::OP_STATUS_WRITE_CMD, 24'h00_0000, 8'h00);
      wait_ready();
      rd(8'h00);
      send(fsw_pkg::OP_WRITE_ENABLE_CMD, 24'h00_0000, 8'h00);
      n = n_req;
      send(fsw_pkg::OP_FULL_ERASE, 24'h00_0000, 8'h00);
      chk(n_req, n + 1);
      chk(last_req.op, fsw_pkg::OP_FULL_ERASE);
      wait_ready();
      rd(8'h00);
      $display("lock test done");
   endtask

   // main sequence
   initial begin
      rst_n     = 1'b0;
      wp_n      = 1'b1;
      h_go      = 1'b0;
      h_cmd     = '0;
      bad_count = 0;
      n_checks  = 0;
      eng_dly   = 1;
      repeat (10) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      t_reset();
      t_latch();
      t_refuse();
      t_program();
      t_abort();
      t_status_write_cmd();
      t_lock();
      end_of_test();
   end
endmodule // test_flash_status_write_enable
